// ### sas_core_model.sv
// Purpose: Behavioural sample-and-hold and comparator beside the sequencer.
// Assumes: Ideal comparator; one level per channel from the bench.
// Notes: Internal reference inverts the scale so a wrong select shows.
`timescale 1ns/10ps
module sas_core_model
  import sas_pkg::*;
(
  input wire logic clk,
  input wire logic analogEn,
  input wire logic sampleHold,
  input wire logic [9:0] dacCode,
  input wire logic [1:0] channelSel,
  input wire logic refSel,
  input wire logic [39:0] levels,
  output logic cmpIn
);
  logic [9:0] heldReg = 10'h000;
  logic togReg = 1'b0;

  // Capture the selected input at the sample point
  // channel and reference
  always @(posedge clk) begin
    togReg <= !togReg;
    if (sampleHold) begin
      heldReg <= refSel ? ~levels[channelSel*10 +: 10] : levels[channelSel*10 +: 10];
    end
  end

  // Unpowered comparator output wanders every cycle
  assign cmpIn = analogEn ? (heldReg >= dacCode) : togReg;
endmodule // sas_core_model

// ### sas_defs.svh
// Purpose: Named offsets, fields, reset values and timing for the converter sequencer.
// Assumes: 32-bit Wishbone words; each register uses one aligned word.
// Notes: Timing figures are in half converter clock cycles from conversion start.
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// Register byte addresses
`define SAS_OFS_CTLA 5'h00
`define SAS_OFS_CTLB 5'h04
`define SAS_OFS_INSEL 5'h08
`define SAS_OFS_RESL 5'h0C
`define SAS_OFS_RESH 5'h10

// Field positions in converter_control_a
`define SAS_CA_EN 7
`define SAS_CA_START 6
`define SAS_CA_AUTO 5
`define SAS_CA_FLAG 4
`define SAS_CA_IRQE 3
`define SAS_CA_PS 2:0

// Field positions in converter_control_b and input_select_register
`define SAS_CB_TS 2:0
`define SAS_IS_REF 6
`define SAS_IS_LEFT 5
`define SAS_IS_CHAN 1:0

// Reset and fill values
`define SAS_ZERO32 32'h0000_0000
`define SAS_PRE_FULL 7'h7F
`define SAS_PS_MAX 3'h7
`define SAS_PS_MIN 3'h1
`define SAS_TS_SELF 3'h0
`define SAS_DAC_MSB 10'h200
`define SAS_SAR_STEPS 4'hA

// Half-cycle marks: sample point and completion point
`define SAS_NORM_SH 6'h03
`define SAS_NORM_DONE 6'h1A
`define SAS_FIRST_SH 6'h1B
`define SAS_FIRST_DONE 6'h32
`define SAS_AUTO_SH 6'h04
`define SAS_AUTO_DONE 6'h1B
`define SAS_LAST_CYC 6'h02

`endif

// ### sas_pkg.sv
// Purpose: Types shared by the converter sequencer.
// Assumes: Field widths fixed by the converter.
// Notes: All module state is one packed struct.
package sas_pkg;

  typedef enum logic [1:0] {SAS_IDLE, SAS_WAIT, SAS_CONV} sas_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic en;
    logic auto;
    logic flag;
    logic irqEn;
    logic [2:0] ps;
    logic [2:0] ts;
    logic refSel;
    logic left;
    logic [1:0] chan;
    logic [9:0] result;
    logic lock;
    logic [6:0] pre;
    logic clkLvl;
    logic first;
    logic autoT;
    sas_state_t st;
    logic [5:0] half;
    logic [3:0] bits;
    logic [9:0] dac;
    logic sh;
    logic bufRef;
    logic [1:0] bufChan;
    logic [7:0] trigS1;
    logic [7:0] trigS2;
    logic [7:0] trigPrev;
    logic cmpS1;
    logic cmpS2;
    logic busy;
  } sas_regs_t;

endpackage

// ### sas_sequencer.sv
// Purpose: Sequencer for a 10-bit successive approximation converter with Wishbone registers.
// Assumes: One clock; trigger and comparator inputs are asynchronous and synchronised here.
// Notes: The converter clock is a tick pair (rise, fall) derived from the prescaler.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`include "sas_defs.svh"

// Notes on behaviour
// - Writing start begins one conversion; start reads set until hardware clears it.
// - Ten-bit result spans two bytes, right aligned unless left align set.
// - Low byte read locks results until high read; done flag still sets.
// - Auto trigger rising edge resets prescaler and starts a conversion.
// - Edges during conversion ignored; a still-high trigger does not restart.
// - Done flag sets regardless of enables; source flag must clear between events.
// - Done flag as source runs back-to-back, first started by start bit.
// - Start reads one during any conversion; start write still works with auto.
// - Prescaler counts while enable set and is held reset while clear.
// - Software start begins at the next rising converter clock edge.
// - Normal conversion is 13 converter cycles, first after enable is 25.
// - Sample at 1.5 cycles normally, 13.5 cycles in the first conversion.
// - Completion writes result, sets done flag, clears start in single mode.
// - Triggered: sample two cycles after edge, conversion lasts 13.5 cycles.
// - Free running restarts immediately after completion and keeps start set.
// - Selection buffer tracks until start, locks, resumes in last cycle.
// - Channel and reference selections only take effect while enabled.
// - Free-run selection change applies after the already started conversion.
// - Channel codes 00..11 select inputs 0..3.
// - Reference select 0 picks supply, 1 picks internal reference.
// - Alignment change alters presented result at once.
module sas_sequencer
  import sas_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] trigIn,
  input wire logic cmpIn,
  output logic analogEn,
  output logic convClk,
  output logic sampleHold,
  output logic [9:0] dacCode,
  output logic [1:0] channelSel,
  output logic refSel,
  output logic busy
);

  localparam sas_regs_t RESET_VAL = '{
    st: SAS_IDLE, first: 1'b1, default: '0};

  sas_regs_t r_reg;
  sas_regs_t r_next;

  logic take;
  logic wrLow;
  logic startWr;
  logic [7:0] resLow;
  logic [7:0] resHigh;
  logic [2:0] psEff;
  logic [6:0] mask;
  logic rise;
  logic fall;
  logic trigEdge;
  logic [5:0] halfNew;
  logic [5:0] shHalf;
  logic [5:0] doneHalf;
  logic lastCyc;
  logic [3:0] bitIdx;

  // Outputs straight from the state register
  assign wb_dat_o = r_reg.rdat;
  assign wb_ack_o = r_reg.ack;
  assign analogEn = r_reg.en;
  assign convClk = r_reg.clkLvl;
  assign sampleHold = r_reg.sh;
  assign dacCode = r_reg.dac;
  assign channelSel = r_reg.bufChan;
  assign refSel = r_reg.bufRef;
  assign busy = r_reg.busy;

  // Next-state logic for the whole block
  always_comb begin
    r_next = r_reg;
    take = 1'b0;
    wrLow = 1'b0;
    startWr = 1'b0;
    resLow = 8'h00;
    resHigh = 8'h00;
    psEff = `SAS_PS_MIN;
    mask = `SAS_PRE_FULL;
    rise = 1'b0;
    fall = 1'b0;
    trigEdge = 1'b0;
    halfNew = r_reg.half;
    shHalf = `SAS_NORM_SH;
    doneHalf = `SAS_NORM_DONE;
    lastCyc = 1'b0;
    bitIdx = 4'h0;
    r_next.ack = 1'b0;
    r_next.sh = 1'b0;

    // Two-stage synchronisers; edge detect compares the second stage with its delayed copy
    r_next.trigS1 = trigIn;
    r_next.trigS2 = r_reg.trigS1;
    r_next.trigPrev = r_reg.trigS2;
    r_next.cmpS1 = cmpIn;
    r_next.cmpS2 = r_reg.cmpS1;

    if (r_reg.left) begin
      resHigh = r_reg.result[9:2];
      resLow = {r_reg.result[1:0], 6'h00};
    end else begin
      resHigh = {6'h00, r_reg.result[9:8]};
      resLow = r_reg.result[7:0];
    end

    // Wishbone slave: one-cycle answer, unmapped reads zero
    take = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    wrLow = take & wb_we_i & wb_sel_i[0];
    if (take) begin
      r_next.ack = 1'b1;
      r_next.rdat = `SAS_ZERO32;
      if (!wb_we_i) begin
        case (wb_adr_i)
          `SAS_OFS_CTLA: begin
            r_next.rdat[`SAS_CA_EN] = r_reg.en;
            // Start reads one during any conversion
            r_next.rdat[`SAS_CA_START] = r_reg.st != SAS_IDLE;
            r_next.rdat[`SAS_CA_AUTO] = r_reg.auto;
            r_next.rdat[`SAS_CA_FLAG] = r_reg.flag;
            r_next.rdat[`SAS_CA_IRQE] = r_reg.irqEn;
            r_next.rdat[`SAS_CA_PS] = r_reg.ps;
          end
          `SAS_OFS_CTLB: r_next.rdat[`SAS_CB_TS] = r_reg.ts;
          `SAS_OFS_INSEL: begin
            r_next.rdat[`SAS_IS_REF] = r_reg.refSel;
            r_next.rdat[`SAS_IS_LEFT] = r_reg.left;
            r_next.rdat[`SAS_IS_CHAN] = r_reg.chan;
          end
          `SAS_OFS_RESL: begin
            r_next.rdat[7:0] = resLow;
            r_next.lock = 1'b1;
          end
          `SAS_OFS_RESH: begin
            r_next.rdat[7:0] = resHigh;
            r_next.lock = 1'b0;
          end
          default: r_next.rdat = `SAS_ZERO32;
        endcase
      end
    end

    // Register writes through byte lane 0
    if (wrLow) begin
      case (wb_adr_i)
        `SAS_OFS_CTLA: begin
          r_next.en = wb_dat_i[`SAS_CA_EN];
          r_next.auto = wb_dat_i[`SAS_CA_AUTO];
          r_next.irqEn = wb_dat_i[`SAS_CA_IRQE];
          r_next.ps = wb_dat_i[`SAS_CA_PS];
          // Done flag clears on a written one
          if (wb_dat_i[`SAS_CA_FLAG]) begin
            r_next.flag = 1'b0;
          end
          startWr = wb_dat_i[`SAS_CA_START];
        end
        `SAS_OFS_CTLB: r_next.ts = wb_dat_i[`SAS_CB_TS];
        `SAS_OFS_INSEL: begin
          r_next.refSel = wb_dat_i[`SAS_IS_REF];
          r_next.left = wb_dat_i[`SAS_IS_LEFT];
          r_next.chan = wb_dat_i[`SAS_IS_CHAN];
        end
        default: r_next.ps = r_next.ps;
      endcase
    end

    // Power-of-two divide; codes 0 and 1 both divide by two
    psEff = (r_reg.ps == 3'h0) ? `SAS_PS_MIN : r_reg.ps;
    mask = `SAS_PRE_FULL >> (`SAS_PS_MAX - psEff);

    if (!r_next.en) begin
      r_next.pre = 7'h00;
      r_next.clkLvl = 1'b0;
      r_next.st = SAS_IDLE;
      r_next.first = 1'b1;
      r_next.half = 6'h00;
      r_next.bits = 4'h0;
    end else begin
      rise = r_reg.pre == mask;
      fall = r_reg.pre == (mask >> 1);
      r_next.pre = rise ? 7'h00 : 7'(r_reg.pre + 7'h01);
      if (rise) begin
        r_next.clkLvl = 1'b1;
      end else if (fall) begin
        r_next.clkLvl = 1'b0;
      end
    end

    // Rising edge of the chosen trigger, other than the done flag
    trigEdge = r_reg.trigS2[r_reg.ts] & ~r_reg.trigPrev[r_reg.ts];

    // Conversion timing marks
    if (r_reg.first) begin
      // First conversion: 25 cycles, sample at 13.5
      shHalf = `SAS_FIRST_SH;
      doneHalf = `SAS_FIRST_DONE;
    end else if (r_reg.autoT) begin
      // Triggered: sample 2 cycles in, 13.5 cycles long
      shHalf = `SAS_AUTO_SH;
      doneHalf = `SAS_AUTO_DONE;
    end else begin
      // Normal: 13 cycles, sample at 1.5
      shHalf = `SAS_NORM_SH;
      doneHalf = `SAS_NORM_DONE;
    end
    halfNew = (rise | fall) ? 6'(r_reg.half + 6'h01) : r_reg.half;
    lastCyc = halfNew >= 6'(doneHalf - `SAS_LAST_CYC);
    bitIdx = 4'(r_reg.bits - 4'h1);

    // Conversion sequencer
    if (r_next.en) begin
      case (r_reg.st)
        SAS_IDLE: begin
          if (startWr) begin
            // Start write begins one conversion, auto or not
            r_next.st = SAS_WAIT;
          end else if (r_reg.auto && r_reg.ts != `SAS_TS_SELF && trigEdge) begin
            // Trigger resets the prescaler and starts at once
            r_next.st = SAS_CONV;
            r_next.pre = 7'h00;
            r_next.clkLvl = 1'b0;
            r_next.half = 6'h00;
            r_next.autoT = 1'b1;
          end
        end
        SAS_WAIT: begin
          // Begin on the next rising converter clock
          if (rise) begin
            r_next.st = SAS_CONV;
            r_next.half = 6'h00;
            r_next.autoT = 1'b0;
          end
        end
        SAS_CONV: begin
          // Trigger edges are not looked at while converting
          r_next.half = halfNew;
          if ((rise | fall) && halfNew == shHalf) begin
            // Sample and hold, then set the first trial bit
            r_next.sh = 1'b1;
            r_next.dac = `SAS_DAC_MSB;
            r_next.bits = `SAS_SAR_STEPS;
          end else if (rise && r_reg.bits != 4'h0) begin
            // Keep the trial bit if the input is above it, try the next
            if (!r_reg.cmpS2) begin
              r_next.dac[bitIdx] = 1'b0;
            end
            if (bitIdx != 4'h0) begin
              r_next.dac[4'(bitIdx - 4'h1)] = 1'b1;
            end
            r_next.bits = bitIdx;
          end
          if ((rise | fall) && halfNew == doneHalf) begin
            // Flag sets regardless of enables; set wins over clear
            r_next.flag = 1'b1;
            // A locked result discards the new value
            if (!r_next.lock) begin
              r_next.result = r_reg.dac;
            end
            r_next.first = 1'b0;
            r_next.bits = 4'h0;
            if (r_reg.auto && r_reg.ts == `SAS_TS_SELF) begin
              // Free running: restart now, start stays set
              r_next.half = 6'h00;
              r_next.autoT = 1'b0;
            end else begin
              // Single mode: start clears with the flag
              r_next.st = SAS_IDLE;
            end
          end
        end
        default: r_next.st = SAS_IDLE;
      endcase
    end

    // Buffer tracks outside conversion and in its last cycle
    if (!r_next.en) begin
      // Selections only reach the core while enabled
      r_next.bufChan = 2'h0;
      r_next.bufRef = 1'b0;
    end else if (r_reg.st != SAS_CONV || lastCyc) begin
      // Channel code and reference pass unchanged
      r_next.bufChan = r_next.chan;
      r_next.bufRef = r_next.refSel;
    end

    // Busy output registered so it leaves straight from a flip-flop
    r_next.busy = r_next.st != SAS_IDLE;
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_reg <= RESET_VAL;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

endmodule // sas_sequencer

// ### sas_sequencer_checker.sv
// Purpose: Port-level timing checks for the converter sequencer.
// Assumes: One clock domain, synchronous active high reset.
// Notes: Attached to every sequencer by the bind at the foot.
`timescale 1ns/10ps
`include "sas_defs.svh"
module sas_sequencer_checker
  import sas_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic analogEn,
  input wire logic convClk,
  input wire logic sampleHold,
  input wire logic [9:0] dacCode,
  input wire logic [1:0] channelSel,
  input wire logic refSel,
  input wire logic busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Bus answers, converter clock gating and behaviour while disabled
  a_ack_one_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data above byte not zero");
  a_clk_held_off: assert property ((!analogEn) [*2] |-> !convClk)
    else $error("converter clock runs while disabled");
  a_clk_starts: assert property ($rose(analogEn) |-> ##[1:300] $changed(convClk))
    else $error("converter clock idle after enable");
  a_abort_idle: assert property ($fell(analogEn) |-> ##[0:2] !busy)
    else $error("busy kept after disable");
  a_sel_off_zero: assert property ((!analogEn) [*2] |-> channelSel == 2'h0 && !refSel)
    else $error("selection live while disabled");

  // Sample point and selection lock
  a_sel_locked: assert property (sampleHold |=> $stable(channelSel) && $stable(refSel))
    else $error("selection moved after sample");
  a_trial_msb: assert property (sampleHold |-> ##[0:2] dacCode == `SAS_DAC_MSB)
    else $error("first trial code wrong");
  a_hold_pulse: assert property (sampleHold |-> busy ##1 !sampleHold)
    else $error("sample pulse outside conversion");
  a_no_early_hold: assert property ($rose(busy) |-> !sampleHold [*3])
    else $error("sample too early");
endmodule // sas_sequencer_checker

bind sas_sequencer sas_sequencer_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .analogEn(analogEn), .convClk(convClk), .sampleHold(sampleHold), .dacCode(dacCode),
  .channelSel(channelSel), .refSel(refSel), .busy(busy));

// ### sas_sequencer_tb.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: ce held high; prescale code 6 puts the converter clock in band.
// Notes: Read answers are scored against a queue by a separate monitor.
`timescale 1ns/10ps
`include "sas_defs.svh"
module sas_sequencer_tb
  import sas_pkg::*;
;
  typedef struct packed {logic [31:0] mask; logic [31:0] val;} sas_exp_t;
  localparam logic [31:0] byteMask = 32'h0000_00FF;
  sas_exp_t expQ[$];
  sas_exp_t e;
  logic clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = `SAS_ZERO32;
  logic [7:0] trigIn = 8'h00;
  logic [39:0] levels = 40'h00_0000_0000;
  logic [31:0] rdat;
  logic ack, cmpIn, analogEn, convClk, sampleHold, refSel, busy;
  logic [9:0] dacCode, oldRes;
  logic [1:0] channelSel;
  int err_total = 0, cmp_count = 0, holds = 0, n;

  always #50 clk = !clk;

  sas_sequencer uut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .trigIn(trigIn), .cmpIn(cmpIn), .analogEn(analogEn), .convClk(convClk),
    .sampleHold(sampleHold), .dacCode(dacCode), .channelSel(channelSel), .refSel(refSel),
    .busy(busy));
  sas_core_model u_core (.clk(clk), .analogEn(analogEn), .sampleHold(sampleHold),
    .dacCode(dacCode), .channelSel(channelSel), .refSel(refSel), .levels(levels), .cmpIn(cmpIn));

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  // One classic cycle; held until ack is seen, then released at that edge
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic [31:0] x);
    expQ.push_back({m, x});
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask

  task automatic rdRes(input logic [9:0] r, input logic lf);
    wb(1'b0, `SAS_OFS_RESL, `SAS_ZERO32, byteMask,
      lf ? {24'h00_0000, r[1:0], 6'h00} : {24'h00_0000, r[7:0]});
    wb(1'b0, `SAS_OFS_RESH, `SAS_ZERO32, byteMask,
      lf ? {24'h00_0000, r[9:2]} : {30'h0000_0000, r[9:8]});
  endtask

  // Counts cycles until the conversion ends
  task automatic conv(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (busy === 1'b1 && c < 8000);
  endtask

  // Score each answer with a nonzero mask against the oldest note; count sample pulses
  always @(negedge clk) begin
    if (sampleHold === 1'b1) holds++;
    if (ack === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      if (e.mask != `SAS_ZERO32) begin
        cmp_count++;
        if ((rdat & e.mask) !== e.val) begin
          err_total++;
          $display("Error at %0t: read %h expected %h", $time, rdat, e.val);
        end
      end
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(76));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset state, unmapped place, refusals while disabled
    wb(1'b0, `SAS_OFS_CTLA, `SAS_ZERO32, byteMask, `SAS_ZERO32);
    wb(1'b0, 5'h14, `SAS_ZERO32, byteMask, `SAS_ZERO32);
    wb(1'b1, `SAS_OFS_INSEL, 32'h0000_0043, `SAS_ZERO32, `SAS_ZERO32);
    wb(1'b1, `SAS_OFS_CTLA, 32'h0000_0040, `SAS_ZERO32, `SAS_ZERO32);
    wb(1'b0, `SAS_OFS_CTLA, `SAS_ZERO32, 32'h0000_0040, `SAS_ZERO32);
    chk(channelSel === 2'h0 && refSel === 1'b0, "selection live while off");
    $display("Test reset done");
    // First conversion, channel 3 on internal reference; divide by 64 is in band
    levels <= 40'({$urandom(), $urandom()});
    wb(1'b1, `SAS_OFS_CTLA, 32'h0000_00C6, `SAS_ZERO32, `SAS_ZERO32);
    conv(n);
    // 25 cycles of 64 clocks plus up to one cycle waiting for the rising tick
    chk(n >= 1600 && n <= 1665, "first conversion length");
    wb(1'b0, `SAS_OFS_CTLA, `SAS_ZERO32, 32'h0000_0050, 32'h0000_0010);
    rdRes(~levels[39:30], 1'b0);
    $display("Test first done");
    // Every channel; ideal model so the result read again after the left alignment change is kept
    for (int ch = 0; ch < 4; ch++) begin
      wb(1'b1, `SAS_OFS_INSEL, {30'h0000_0000, 2'(ch)}, `SAS_ZERO32, `SAS_ZERO32);
      wb(1'b1, `SAS_OFS_CTLA, 32'h0000_00D6, `SAS_ZERO32, `SAS_ZERO32);
      conv(n);
      // 13 cycles of 64 clocks plus up to one cycle waiting for the rising tick
      chk(n >= 832 && n <= 897, "normal conversion length");
      rdRes(levels[ch*10 +: 10], 1'b0);
      wb(1'b1, `SAS_OFS_INSEL, {26'h000_0000, 1'b1, 3'h0, 2'(ch)}, `SAS_ZERO32, `SAS_ZERO32);
      rdRes(levels[ch*10 +: 10], 1'b1);
    end
    $display("Test channels done");
    // Low byte read holds the result across a completion
    wb(1'b1, `SAS_OFS_INSEL, `SAS_ZERO32, `SAS_ZERO32, `SAS_ZERO32);
    wb(1'b1, `SAS_OFS_CTLA, 32'h0000_00D6, `SAS_ZERO32, `SAS_ZERO32);
    conv(n);
    oldRes = levels[9:0];
    wb(1'b0, `SAS_OFS_RESL, `SAS_ZERO32, byteMask, {24'h00_0000, oldRes[7:0]});
    levels <= ~levels;
    wb(1'b1, `SAS_OFS_CTLA, 32'h0000_00D6, `SAS_ZERO32, `SAS_ZERO32);
    conv(n);
    wb(1'b0, `SAS_OFS_CTLA, `SAS_ZERO32, 32'h0000_0050, 32'h0000_0010);
    wb(1'b0, `SAS_OFS_RESH, `SAS_ZERO32, byteMask, {30'h0000_0000, oldRes[9:8]});
    rdRes(oldRes, 1'b0);
    $display("Test lock done");
    // Free running on the done flag, never cleared, then abort by disable
    wb(1'b1, `SAS_OFS_CTLB, `SAS_ZERO32, `SAS_ZERO32, `SAS_ZERO32);
    n = holds;
    wb(1'b1, `SAS_OFS_CTLA, 32'h0000_00E6, `SAS_ZERO32, `SAS_ZERO32);
    // Room for three sample points at 13 cycles of 64 clocks each
    repeat (1900) @(negedge clk);
    wb(1'b0, `SAS_OFS_CTLA, `SAS_ZERO32, 32'h0000_0040, 32'h0000_0040);
    chk(holds - n >= 3, "free run stalled");
    wb(1'b1, `SAS_OFS_CTLA, `SAS_ZERO32, `SAS_ZERO32, `SAS_ZERO32);
    wb(1'b0, `SAS_OFS_CTLA, `SAS_ZERO32, 32'h0000_0040, `SAS_ZERO32);
    $display("Test free run done");
    // Trigger source 1: edge starts, held level and mid-conversion edge do not
    wb(1'b1, `SAS_OFS_CTLB, 32'h0000_0001, `SAS_ZERO32, `SAS_ZERO32);
    wb(1'b1, `SAS_OFS_CTLA, 32'h0000_00B6, `SAS_ZERO32, `SAS_ZERO32);
    @(posedge clk) trigIn <= 8'h02;
    repeat (6) @(negedge clk);
    chk(busy === 1'b1, "trigger did not start");
    conv(n);
    repeat (100) @(negedge clk);
    chk(busy === 1'b0, "held trigger restarted");
    wb(1'b1, `SAS_OFS_CTLA, 32'h0000_00B6, `SAS_ZERO32, `SAS_ZERO32);
    @(posedge clk) trigIn <= 8'h00;
    @(posedge clk) trigIn <= 8'h02;
    repeat (8) @(posedge clk);
    trigIn <= 8'h00;
    @(posedge clk) trigIn <= 8'h02;
    conv(n);
    // 13.5 cycles of 64 clocks from the synchronised edge, counted from 9 clocks after the pin
    chk(n >= 850 && n <= 864, "triggered conversion length");
    repeat (100) @(negedge clk);
    chk(busy === 1'b0, "edge during conversion kept");
    $display("Test trigger done");
    tally_and_finish();
  end
endmodule // sas_sequencer_tb
